// ==== rtl/omsel_pkg.sv ====
// Purpose: shared constants and types for the one-of-n mode selector
// Assumes: 100 MHz clock; discrepancy time counted in 10 ms steps
// Notes: step count is derived from the clock rate
package omsel_pkg;
    localparam int OMSEL_CLK_HZ = 100_000_000;
    localparam int OMSEL_STEP_MS = 10;
    localparam int OMSEL_STEP_CYCLES = OMSEL_CLK_HZ / 1000 * OMSEL_STEP_MS;
    localparam int OMSEL_MAX_TIME_MS = 10_000;
    localparam int OMSEL_MAX_STEPS = OMSEL_MAX_TIME_MS / OMSEL_STEP_MS;
    localparam int OMSEL_STEP_W = $clog2(OMSEL_MAX_STEPS + 1);
    localparam int OMSEL_MIN_N = 2;
    localparam int OMSEL_MAX_N = 8;

    typedef enum logic [1:0] {
        OMSEL_ST_START,
        OMSEL_ST_VALID,
        OMSEL_ST_WAIT,
        OMSEL_ST_FAULT
    } omsel_state_t;

    typedef struct packed {
        logic [OMSEL_STEP_W-1:0] disc_steps;
        logic [OMSEL_MAX_N-1:0] err_pattern;
        logic use_fault;
    } omsel_cfg_t;
endpackage : omsel_pkg

// ==== rtl/omsel_sync.sv ====
// Purpose: two flip-flop synchroniser for a bus of pin levels
// Assumes: inputs are asynchronous to i_mclk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module omsel_sync #(
    parameter int WIDTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (i_ce) begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule : omsel_sync
`default_nettype wire

// ==== rtl/omsel_top.sv ====
// Purpose: one-of-n mode selector with discrepancy timer and error pattern
// Assumes: i_run high means run; leaving run acts as a restart
// Notes: evaluation is every enabled clock cycle
//
// Contract
// - one high input drives matching output only
// - two to eight inputs and outputs
// - invalid inputs hold last output during timeout
// - timeout expiry raises fault, applies pattern
// - shorter or equal invalid no fault, longer faults
// - invalid on first run cycle faults immediately
// - discrepancy time zero to ten seconds, 10 ms
// - error pattern mask drives outputs during fault
`timescale 1ns/1ps
`default_nettype none
module omsel_top
    import omsel_pkg::*;
#(
    parameter int N = 8,
    parameter int STEP_CYCLES = OMSEL_STEP_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_run,
    input wire logic [N-1:0] i_sel,
    input wire omsel_cfg_t i_cfg,
    output logic [N-1:0] o_sel,
    output logic o_fault
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (N < OMSEL_MIN_N || N > OMSEL_MAX_N) begin : g_bad_n
        // stop elaboration: input count outside two to eight
        $error("omsel_top: N out of range");
    end

    localparam int PRE_W = $clog2(STEP_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic [N-1:0] sel_s;
    logic [0:0] run_s;

    omsel_sync #(.WIDTH(N)) u_sync_sel (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_async(i_sel),
        .o_sync(sel_s)
    );

    omsel_sync #(.WIDTH(1)) u_sync_run (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_async(i_run),
        .o_sync(run_s)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic valid;
    logic [N-1:0] pattern;
    logic [OMSEL_STEP_W-1:0] limit;

    // exactly one bit set: nonzero and no other bit
    assign valid = (sel_s != '0) && ((sel_s & (sel_s - N'(1))) == '0);
    assign pattern = i_cfg.err_pattern[N-1:0];
    // clamp so an out-of-range setting cannot exceed ten seconds
    assign limit = (i_cfg.disc_steps > OMSEL_STEP_W'(OMSEL_MAX_STEPS)) ?
                   OMSEL_STEP_W'(OMSEL_MAX_STEPS) : i_cfg.disc_steps;

    // ------------------------------------------------------------
    // state and timer
    // ------------------------------------------------------------
    omsel_state_t state_ff;
    omsel_state_t nxt_state;
    logic [PRE_W-1:0] pre_ff;
    logic [OMSEL_STEP_W-1:0] steps_ff;
    logic step_tick;
    logic expired;

    assign step_tick = (pre_ff == PRE_LAST);
    // elapsed step count reaching the limit means equal time has passed
    assign expired = (steps_ff >= limit);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            OMSEL_ST_START: begin
                nxt_state = valid ? OMSEL_ST_VALID : OMSEL_ST_FAULT;
            end
            OMSEL_ST_VALID: begin
                if (!valid) begin
                    // zero discrepancy time faults on first invalid cycle
                    nxt_state = (limit == '0) ? OMSEL_ST_FAULT : OMSEL_ST_WAIT;
                end
            end
            OMSEL_ST_WAIT: begin
                if (valid) begin
                    nxt_state = OMSEL_ST_VALID;
                end else if (expired) begin
                    nxt_state = OMSEL_ST_FAULT;
                end
            end
            OMSEL_ST_FAULT: begin
                if (valid) begin
                    nxt_state = OMSEL_ST_VALID;
                end
            end
            default: begin
                nxt_state = OMSEL_ST_START;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= OMSEL_ST_START;
        end else if (i_ce) begin
            // stop state forces a fresh first-cycle check on next run
            state_ff <= run_s[0] ? nxt_state : OMSEL_ST_START;
        end
    end

    // timer: prescaler to 10 ms steps, counting only while waiting
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            pre_ff <= '0;
            steps_ff <= '0;
        end else if (i_ce) begin
            if (state_ff != OMSEL_ST_WAIT || nxt_state != OMSEL_ST_WAIT) begin
                pre_ff <= '0;
                // entering wait clears the count; the first invalid cycle is not counted
                steps_ff <= '0;
            end else if (step_tick) begin
                pre_ff <= '0;
                steps_ff <= steps_ff + OMSEL_STEP_W'(1);
            end else begin
                pre_ff <= pre_ff + PRE_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic [N-1:0] out_ff;
    logic fault_ff;

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            out_ff <= '0;
        end else if (i_ce) begin
            if (!run_s[0]) begin
                out_ff <= '0;
            end else if (nxt_state == OMSEL_ST_VALID) begin
                out_ff <= sel_s;
            end else if (nxt_state == OMSEL_ST_FAULT) begin
                out_ff <= pattern;
            end
            // wait state: last valid output is simply held
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            fault_ff <= 1'b0;
        end else if (i_ce) begin
            fault_ff <= run_s[0] && (nxt_state == OMSEL_ST_FAULT);
        end
    end

    assign o_sel = out_ff;
    // fault output reads low when the option is not in use
    assign o_fault = fault_ff & i_cfg.use_fault;
endmodule : omsel_top
`default_nettype wire

// ==== sim/omsel_props.sv ====
// Purpose: output checks for the selector
// Assumes: i_ce high; pins reach outputs in three edges
// Notes: counter of invalid cycles bounds the wait
`timescale 1ns/1ps
`default_nettype none
module omsel_props
    import omsel_pkg::*;
#(
    parameter int N = 8,
    parameter int STEP_CYCLES = 4
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_run,
    input wire logic [N-1:0] i_sel,
    input wire omsel_cfg_t i_cfg,
    input wire logic [N-1:0] o_sel,
    input wire logic o_fault
);
    int bad_ff;
    int lim;
    assign lim = int'(i_cfg.disc_steps) * STEP_CYCLES;
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) bad_ff <= 0;
        else if (!i_run || $onehot(i_sel) || !i_ce) bad_ff <= 0;
        else if (bad_ff < 60000) bad_ff <= bad_ff + 1;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    a_fault_pattern: assert property (o_fault |-> o_sel == i_cfg.err_pattern[N-1:0])
        else $error("fault pattern wrong");
    a_fault_gate: assert property (!i_cfg.use_fault |-> !o_fault)
        else $error("fault flag not gated");
    a_onehot_follow: assert property ((i_run && $onehot(i_sel) && $stable(i_sel))[*4]
        |=> o_sel == $past(i_sel) && !o_fault) else $error("one-hot not followed");
    a_hold_last: assert property ($changed(o_sel) && !o_fault && !$past(o_fault)
        && i_cfg.use_fault && $past(i_run, 3) |-> $onehot($past(i_sel, 3)))
        else $error("output moved on invalid input");
    a_first_cycle: assert property (!$past(i_run, 4) && $past(i_run, 3) && i_cfg.use_fault
        && !$onehot($past(i_sel, 3)) |-> ##[0:1] o_fault) else $error("no start fault");
    a_late_fault: assert property ($rose(o_fault) && $past(o_sel) != '0 |-> bad_ff >= lim)
        else $error("fault too early");
    a_timeout_fault: assert property (bad_ff > lim + 8 && i_cfg.use_fault |-> o_fault)
        else $error("fault missing after timeout");
    a_out_shape: assert property (i_cfg.use_fault && !o_fault |-> $onehot0(o_sel))
        else $error("output not one-hot");
    cover property ($rose(o_fault) && $past(o_sel) != '0);
    cover property ($rose(o_fault) && $past(o_sel) == '0);
    cover property (o_sel[N-1] && !o_fault);
endmodule : omsel_props
bind omsel_top omsel_props #(.N(N), .STEP_CYCLES(STEP_CYCLES)) omsel_props_i (.i_mclk(i_mclk),
    .i_reset(i_reset), .i_ce(i_ce), .i_run(i_run), .i_sel(i_sel), .i_cfg(i_cfg),
    .o_sel(o_sel), .o_fault(o_fault));
`default_nettype wire

// ==== sim/omsel_switch.sv ====
// Purpose: mode switch contacts
// Assumes: mode 0 one contact, 1 none, 2 two
// Notes: contact 7 stands in for a stuck contact
`timescale 1ns/1ps
`default_nettype none
module omsel_switch (
    input wire logic [2:0] i_pos,
    input wire logic [1:0] i_mode,
    output logic [7:0] o_pin
);
    always_comb begin
        o_pin = 8'h01 << i_pos;
        if (i_mode == 2'd1) o_pin = 8'h00;
        if (i_mode == 2'd2) o_pin = o_pin | 8'h80;
    end
endmodule : omsel_switch
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: selector bench
// Assumes: step of 4 cycles, i_ce tied high
// Notes: outputs looked at three or more edges after pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import omsel_pkg::*;
    logic i_mclk = 0;
    logic i_reset = 1;
    logic i_run = 0;
    logic [2:0] pos = 0;
    logic [1:0] mode = 1;
    logic [7:0] pin;
    logic [7:0] o_sel;
    logic o_fault;
    omsel_cfg_t cfg = '{disc_steps: 10'd3, err_pattern: 8'h5a, use_fault: 1'b1};
    int bad_count = 0;
    int checks = 0;
    omsel_switch omsel_switch_i (.i_pos(pos), .i_mode(mode), .o_pin(pin));
    omsel_top #(.N(8), .STEP_CYCLES(4)) omsel_top_i (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_ce(1'b1), .i_run(i_run), .i_sel(pin), .i_cfg(cfg), .o_sel(o_sel), .o_fault(o_fault));
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic step(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : step
    task automatic give_verdict();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(input logic f, input logic [7:0] s);
        checks++;
        if ({o_fault, o_sel} !== {f, s}) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, {o_fault, o_sel}, {f, s});
        end
    endtask : check
    // bounded wait: a fault that never comes ends the run
    task automatic wait_fault(input int bound);
        int k;
        for (k = 0; k < bound && o_fault !== 1'b1; k++) step(1);
        if (k == bound) begin
            bad_count++;
            give_verdict();
        end
        else check(1'b1, cfg.err_pattern);
    endtask : wait_fault
    initial begin
        step(20);
        i_reset = 0;
        step(2);
        i_run = 1;
        wait_fault(6);
        for (int k = 0; k < 8; k++) begin
            pos = k[2:0];
            mode = 0;
            step(4);
            check(1'b0, 8'h01 << k);
        end
        mode = 1;
        step(6);
        check(1'b0, 8'h80);
        pos = 2;
        mode = 0;
        step(4);
        mode = 2;
        wait_fault(40);
        cfg.use_fault = 0;
        step(1);
        check(1'b0, 8'h5a);
        cfg.use_fault = 1;
        mode = 0;
        step(4);
        check(1'b0, 8'h04);
        cfg.disc_steps = 0;
        mode = 1;
        wait_fault(8);
        i_run = 0;
        step(4);
        check(1'b0, 8'h00);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
